// >>> verilog/uefl_params.svh
// offsets, field positions, reset values and counts of the event/format block
`ifndef UEFL_PARAMS_SVH
`define UEFL_PARAMS_SVH
// ======================================================================
// byte addresses on the register bus
`define UEFL_OFS_EVT 8'h08
`define UEFL_OFS_LINE 8'h0c
`define UEFL_OFS_EXT 8'h10
`define UEFL_OFS_STAT 8'h14
// ======================================================================
// fifo control fields
`define UEFL_FC_EN 0
`define UEFL_FC_RXCLR 1
`define UEFL_FC_TXCLR 2
`define UEFL_FC_TXTH 5:4
`define UEFL_FC_RXTH 7:6
// line format fields
`define UEFL_LF_LEN 1:0
`define UEFL_LF_STB 2
`define UEFL_LF_PEN 3
`define UEFL_LF_EPS 4
`define UEFL_LF_FORCED_PARITY 5
`define UEFL_LF_GATE 7
// extended control one field
`define UEFL_XC_SEL 0
// ======================================================================
// reset values
`define UEFL_RST_BYTE 8'h00
`define UEFL_RST_LEVEL 5'h00
`define UEFL_RST_CNT 6'h00
// ======================================================================
// fifo thresholds, codes 00 to 11
`define UEFL_TXTH0 5'h01
`define UEFL_TXTH1 5'h03
`define UEFL_TXTH2 5'h09
`define UEFL_TXTH3 5'h0d
`define UEFL_RXTH0 5'h01
`define UEFL_RXTH1 5'h04
`define UEFL_RXTH2 5'h08
`define UEFL_RXTH3 5'h0e
// ======================================================================
// time-out: start + 5 data + 1 stop bit times, scaled by character count
`define UEFL_FRAME_MIN 4'h7
`define UEFL_TO_SHIFT 2
`endif

// >>> verilog/uefl_pkg.sv
// types shared by the event, fifo control and line format block
package uefl_pkg;
  // legacy prioritised event codes, bits 3:0 of the event register
  typedef enum logic [3:0] {
    UEFL_EV_NONE = 4'h1,
    UEFL_EV_LINE = 4'h6,
    UEFL_EV_RXDATA = 4'h4,
    UEFL_EV_RXTIMEOUT = 4'hc,
    UEFL_EV_TXLOW = 4'h2,
    UEFL_EV_MODEM = 4'h0
  } uefl_evcode_t;
  // parity bit kind handed to transmitter and receiver
  typedef enum logic [2:0] {
    UEFL_PAR_NONE = 3'h0,
    UEFL_PAR_ODD = 3'h1,
    UEFL_PAR_EVEN = 3'h2,
    UEFL_PAR_ONE = 3'h3,
    UEFL_PAR_ZERO = 3'h4
  } uefl_parity_t;
  // transmit stop length; the receiver always checks one
  typedef enum logic [1:0] {
    UEFL_STOP_ONE = 2'h0,
    UEFL_STOP_HALF = 2'h1,
    UEFL_STOP_TWO = 2'h2
  } uefl_stop_t;
endpackage

// >>> verilog/uefl_core.sv
// event identification, fifo control and line format registers, apb slave
// ======================================================================
// Overview of operation
// R1 - legacy bits 2:1 give top pending priority
// R2 - legacy bit 3 set only for top timeout
// R3 - legacy bits 7:6 mirror fifo enable
// R4 - code 0001 idle, 0110 line error top
// R5 - code 0100 for receive data level
// R6 - code 1100 after four idle character times
// R7 - code 0010 transmit empty, cleared by read/write
// R8 - code 0000 for modem change, lowest
// R9 - extended mode shows each source separately; here the time-out shares bit 0 with receive data
// R10 - extended bit 0 receive data event
// R11 - extended bit 1 transmit low level event
// R12 - extended bit 2 line error event
// R13 - extended bit 3 modem change event
// R14 - extended bit 5 transmitter all empty
// R15 - fifo control write-only, bit 0 enables
// R16 - bits 1,2 self-clearing fifo clears
// R17 - transmit threshold 1,3,9,13 in extended mode
// R18 - receive threshold 1,4,8,14
// R19 - shared address: gate bit protects format
// R20 - bits 1:0 select 5 to 8 data bits
// R21 - stop bits: one, 1.5 or two
// R22 - bit 3 parity on, bit 4 even
// R23 - bit 5 forces parity to constant
// R24 - extended select bit, legacy after reset
// R25 - timeout counter restarts on fifo traffic
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "uefl_params.svh"

module uefl_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // state of the rest of the controller
  input wire logic [4:0] rx_level,
  input wire logic [4:0] tx_level,
  input wire logic rhr_full,
  input wire logic thr_empty,
  input wire logic tx_all_empty,
  input wire logic overrun_err,
  input wire logic char_err,
  input wire logic [3:0] modem_delta,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic tx_push,
  input wire logic baud_tick,
  // control to the rest of the controller
  output logic fifo_on_q,
  output logic rx_clear_q,
  output logic tx_clear_q,
  output logic extended_q,
  output logic [7:0] bank_q,
  output logic [1:0] char_len_q,
  output uefl_pkg::uefl_stop_t stop_code_q,
  output uefl_pkg::uefl_parity_t parity_kind_q
);

  // ======================================================================
  // threshold decode, shared by both directions
  function automatic logic [4:0] thr_of(input logic [1:0] code,
                                        input logic is_rx);
    logic [4:0] v;
    case (code)
      2'h1: v = is_rx ? `UEFL_RXTH1 : `UEFL_TXTH1;
      2'h2: v = is_rx ? `UEFL_RXTH2 : `UEFL_TXTH2;
      2'h3: v = is_rx ? `UEFL_RXTH3 : `UEFL_TXTH3;
      default: v = is_rx ? `UEFL_RXTH0 : `UEFL_TXTH0;
    endcase
    return v;
  endfunction

  // ======================================================================
  // declarations
  logic [7:0] fc_q; // stored fifo control, clear bits kept zero
  logic [7:0] lcr_q; // line format
  logic [5:0] to_cnt_q; // bit times since last fifo traffic
  logic rx_to_q; // receive time-out pending
  logic tx_low_q; // legacy transmit-empty event latch
  logic txe_prev_q; // previous transmit-empty condition
  logic done, wr_done, rd_done; // apb access completes this edge
  logic hit; // address is mapped
  logic [4:0] rx_thr, tx_thr; // decoded thresholds
  logic rx_hi, tx_lo_ext, line_ev, modem_ev, txe_cond, txe_rise;
  logic [3:0] frame_bits; // bit times per character
  logic [5:0] to_limit; // bit times per four characters
  logic [7:0] evt_val; // event register read value
  logic [31:0] rd_mux;
  uefl_pkg::uefl_evcode_t code;

  // ======================================================================
  // apb decode
  // one wait state: pready rises in the second access cycle, so read
  // data is captured from a settled mux and side effects land once
  assign done = psel & penable & pready_q;
  assign wr_done = done & pwrite;
  assign rd_done = done & ~pwrite;
  assign hit = (paddr == `UEFL_OFS_EVT) || (paddr == `UEFL_OFS_LINE) ||
               (paddr == `UEFL_OFS_EXT) || (paddr == `UEFL_OFS_STAT);

  // read mux; the line address reads back the bank selector
  always_comb begin
    rd_mux = 32'h0;
    case (paddr)
      `UEFL_OFS_EVT: rd_mux = {24'h0, evt_val};
      `UEFL_OFS_LINE: rd_mux = {24'h0, bank_q}; // [R19]
      `UEFL_OFS_EXT: rd_mux = {31'h0, extended_q};
      `UEFL_OFS_STAT: rd_mux = {14'h0, tx_low_q, rx_to_q, fc_q, lcr_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // handshake and answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      // unmapped addresses answer with an error and change nothing
      pslverr_q <= psel & penable & ~pready_q & ~hit;
      if (psel & penable & ~pready_q & ~pwrite) begin
        prdata_q <= rd_mux;
      end else if (done) begin
        prdata_q <= 32'h0;
      end
    end
  end

  // ======================================================================
  // fifo control and enable; reads here return events, never fc_q
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_q <= `UEFL_RST_BYTE;
      fifo_on_q <= 1'b0;
    end else if (wr_done && paddr == `UEFL_OFS_EVT) begin
      fc_q <= {pwdata[7:4], 3'h0, pwdata[`UEFL_FC_EN]}; // [R15]
      fifo_on_q <= pwdata[`UEFL_FC_EN]; // [R15]
    end
  end

  // one-cycle clear pulses; writing enable 0 empties both fifos
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_clear_q <= 1'b0;
      tx_clear_q <= 1'b0;
    end else begin
      rx_clear_q <= wr_done && paddr == `UEFL_OFS_EVT &&
                    (pwdata[`UEFL_FC_RXCLR] || !pwdata[`UEFL_FC_EN]); // [R16]
      tx_clear_q <= wr_done && paddr == `UEFL_OFS_EVT &&
                    (pwdata[`UEFL_FC_TXCLR] || !pwdata[`UEFL_FC_EN]); // [R16]
    end
  end

  // thresholds; the transmit one only matters in extended mode
  assign rx_thr = thr_of(fc_q[`UEFL_FC_RXTH], 1'b1); // [R18]
  assign tx_thr = thr_of(fc_q[`UEFL_FC_TXTH], 1'b0); // [R17]

  // ======================================================================
  // line format and bank selector share one address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_q <= `UEFL_RST_BYTE;
      lcr_q <= `UEFL_RST_BYTE;
    end else if (wr_done && paddr == `UEFL_OFS_LINE) begin
      bank_q <= pwdata[7:0]; // [R19]
      // gate set: format stays put while other banks are reached
      if (!pwdata[`UEFL_LF_GATE]) begin
        lcr_q <= pwdata[7:0]; // [R19]
      end
    end
  end

  // decoded format, one cycle behind the stored byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      char_len_q <= 2'h0;
      stop_code_q <= uefl_pkg::UEFL_STOP_ONE;
    end else begin
      char_len_q <= lcr_q[`UEFL_LF_LEN]; // [R20]
      if (!lcr_q[`UEFL_LF_STB]) begin
        stop_code_q <= uefl_pkg::UEFL_STOP_ONE; // [R21]
      end else if (lcr_q[`UEFL_LF_LEN] == 2'h0) begin
        stop_code_q <= uefl_pkg::UEFL_STOP_HALF; // [R21]
      end else begin
        stop_code_q <= uefl_pkg::UEFL_STOP_TWO; // [R21]
      end
    end
  end

  // parity kind for transmitter generation and receiver checking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_kind_q <= uefl_pkg::UEFL_PAR_NONE;
    end else if (!lcr_q[`UEFL_LF_PEN]) begin
      parity_kind_q <= uefl_pkg::UEFL_PAR_NONE; // [R22]
    end else if (lcr_q[`UEFL_LF_FORCED_PARITY]) begin
      // forced parity: even select inverts the constant
      parity_kind_q <= lcr_q[`UEFL_LF_EPS] ? uefl_pkg::UEFL_PAR_ZERO :
                       uefl_pkg::UEFL_PAR_ONE; // [R23]
    end else begin
      parity_kind_q <= lcr_q[`UEFL_LF_EPS] ? uefl_pkg::UEFL_PAR_EVEN :
                       uefl_pkg::UEFL_PAR_ODD; // [R22]
    end
  end

  // ======================================================================
  // extended select; legacy after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extended_q <= 1'b0; // [R24]
    end else if (wr_done && paddr == `UEFL_OFS_EXT) begin
      extended_q <= pwdata[`UEFL_XC_SEL]; // [R24]
    end
  end

  // ======================================================================
  // receive time-out; 1.5 stop bits counts as two, so the time-out
  // errs on the late side rather than firing mid-character
  assign frame_bits = `UEFL_FRAME_MIN + {2'h0, lcr_q[`UEFL_LF_LEN]} +
                      {3'h0, lcr_q[`UEFL_LF_PEN]} +
                      {3'h0, lcr_q[`UEFL_LF_STB]};
  assign to_limit = {frame_bits, 2'h0} << (`UEFL_TO_SHIFT - 2);

  // bit-time counter, restarted by any receive fifo traffic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt_q <= `UEFL_RST_CNT;
    end else if (rx_push || rx_pop || rx_clear_q ||
                 rx_level == `UEFL_RST_LEVEL) begin
      to_cnt_q <= `UEFL_RST_CNT; // [R25]
    end else if (baud_tick && to_cnt_q != to_limit) begin
      to_cnt_q <= to_cnt_q + 6'h01; // [R25]
    end
  end

  // time-out flag; a data read clears it, fifo traffic restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_to_q <= 1'b0;
    end else if (rx_push || rx_pop || rx_clear_q || !fifo_on_q ||
                 (wr_done && paddr == `UEFL_OFS_EVT &&
                  !pwdata[`UEFL_FC_EN])) begin
      // the enable-off write drops it at once: bit 3 dies with fifos
      rx_to_q <= 1'b0; // [R6] [R2]
    end else if (to_cnt_q == to_limit && rx_level != `UEFL_RST_LEVEL) begin
      rx_to_q <= 1'b1; // [R6]
    end
  end

  // ======================================================================
  // source conditions
  assign rx_hi = fifo_on_q ? (rx_level >= rx_thr) : rhr_full; // [R5]
  assign tx_lo_ext = fifo_on_q ? (tx_level < tx_thr) : thr_empty; // [R11]
  // char_err is for the character at the fifo bottom; overrun is live
  assign line_ev = overrun_err | char_err; // [R12]
  assign modem_ev = |modem_delta; // [R13]
  assign txe_cond = fifo_on_q ? (tx_level == `UEFL_RST_LEVEL) : thr_empty;
  assign txe_rise = txe_cond & ~txe_prev_q;

  // edge memory for the transmit-empty latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txe_prev_q <= 1'b1; // no false edge from an idle empty flag
    end else begin
      txe_prev_q <= txe_cond;
    end
  end

  // legacy transmit event; a new empty edge wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_low_q <= 1'b0;
    end else if (txe_rise) begin
      tx_low_q <= 1'b1; // [R7]
    end else if (tx_push || (rd_done && paddr == `UEFL_OFS_EVT &&
                 !extended_q && code == uefl_pkg::UEFL_EV_TXLOW)) begin
      tx_low_q <= 1'b0; // [R7]
    end
  end

  // ======================================================================
  // legacy priority encoder
  always_comb begin
    if (line_ev) begin
      code = uefl_pkg::UEFL_EV_LINE; // [R4]
    end else if (rx_to_q) begin
      code = uefl_pkg::UEFL_EV_RXTIMEOUT; // [R6] [R2]
    end else if (rx_hi) begin
      code = uefl_pkg::UEFL_EV_RXDATA; // [R5]
    end else if (tx_low_q) begin
      code = uefl_pkg::UEFL_EV_TXLOW; // [R7]
    end else if (modem_ev) begin
      code = uefl_pkg::UEFL_EV_MODEM; // [R8]
    end else begin
      code = uefl_pkg::UEFL_EV_NONE; // [R4] [R1]
    end
  end

  // event register: prioritised code or one flag per source, time-out sharing the receive data flag
  always_comb begin
    if (extended_q) begin
      // flags ignore the interrupt enables
      evt_val = {2'h0, tx_all_empty, 1'b0, modem_ev, line_ev,
                 tx_lo_ext, rx_hi | rx_to_q}; // [R9] [R10] [R14]
    end else begin
      evt_val = {fifo_on_q, fifo_on_q, 2'h0, code}; // [R1] [R3]
    end
  end

  // ======================================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_evt_write;
    wr_done && paddr == `UEFL_OFS_EVT;
  endsequence
  sequence s_gated_write;
    wr_done && paddr == `UEFL_OFS_LINE && pwdata[7];
  endsequence
  a_legacy_line_top: assert property ( // [R4]
    !extended_q && line_ev |-> evt_val[3:0] == 4'h6)
    else $error("line event not top code");
  a_timeout_code: assert property ( // [R6]
    !extended_q && !line_ev && rx_to_q |-> evt_val[3:0] == 4'hc)
    else $error("time-out code wrong");
  a_fifo_mirror_bits: assert property ( // [R3]
    !extended_q |-> evt_val[7:6] == {2{fifo_on_q}} && evt_val[5:4] == 2'h0)
    else $error("fifo mirror bits wrong");
  a_rx_timeout_flag_without_fifo: assert property ( // [R2]
    !extended_q && !fifo_on_q |-> !evt_val[3])
    else $error("time-out bit set without fifos");
  a_ext_reserved_bits: assert property ( // [R14]
    extended_q |-> evt_val[7:6] == 2'h0 && !evt_val[4] &&
    evt_val[5] == tx_all_empty)
    else $error("extended reserved or empty bit wrong");
  a_rx_clear_pulse: assert property ( // [R16]
    s_evt_write ##0 pwdata[1] |=> rx_clear_q ##1 !rx_clear_q)
    else $error("receive clear not a single pulse");
  a_gated_line_hold: assert property ( // [R19]
    s_gated_write |=> $stable(lcr_q) && bank_q == $past(pwdata[7:0]))
    else $error("gated write changed line format");
  a_tx_push_clears: assert property ( // [R7]
    tx_push && !txe_rise |=> !tx_low_q)
    else $error("transmit write did not clear event");
  a_timeout_restart: assert property ( // [R25]
    rx_push || rx_pop |=> !rx_to_q && to_cnt_q == 6'h00)
    else $error("time-out did not restart");
  a_forced_parity: assert property ( // [R23]
    lcr_q[3] && lcr_q[5] && $stable(lcr_q) |=>
    parity_kind_q == ($past(lcr_q[4]) ? uefl_pkg::UEFL_PAR_ZERO :
                      uefl_pkg::UEFL_PAR_ONE))
    else $error("forced parity constant wrong");
endmodule

// >>> test/uefl_apb_host.sv
// apb master model standing in for the host processor
`timescale 1ns/1ps

// ======================================================================
// one transfer per go pulse, completion flagged for one cycle
module uefl_apb_host (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the bench
  input wire logic go,
  input wire logic go_wr,
  input wire logic [7:0] go_addr,
  input wire logic [31:0] go_data,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // completion back to the bench
  output logic done,
  output logic [31:0] rdata,
  output logic err
);
  // request held until pready is sampled high, then released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      done <= 1'b0;
      rdata <= 32'h0;
      err <= 1'b0;
    end else begin
      done <= 1'b0;
      if (psel && penable && pready) begin
        // released bus lines flip so stale values never look valid
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
        done <= 1'b1;
        rdata <= prdata;
        err <= pslverr;
      end else if (psel) begin
        penable <= 1'b1;
      end else if (go) begin
        psel <= 1'b1;
        pwrite <= go_wr;
        paddr <= go_addr;
        pwdata <= go_data;
      end
    end
  end
endmodule

// >>> test/uart_event_fifo_line_ctrl_tb_top.sv
// self-checking bench of the event, fifo control and line format block
`timescale 1ns/1ps
`include "uefl_params.svh"
`define CHECK_EQ(g, e) begin checks_done++; if ((g) !== (e)) begin \
  failures++; $display("MISMATCH at %0t: got %h want %h", $time, g, e); \
  end end

module uart_event_fifo_line_ctrl_tb_top;
  // ======================================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, go_addr, bank;
  logic [31:0] pwdata, prdata, go_data, h_rdata;
  logic go = 1'b0, go_wr = 1'b0, h_done, h_err;
  logic [4:0] rx_level, tx_level;
  logic rhr_full, thr_empty, tx_all_empty, overrun_err, char_err;
  logic [3:0] modem_delta;
  logic [2:0] pul = 3'h0; // one-cycle strobes: rx push, rx pop, tx push
  logic tick_en = 1'b0, baud_tick = 1'b0;
  logic fifo_on, rx_clr, tx_clr, ext;
  logic [1:0] len;
  uefl_pkg::uefl_stop_t stop;
  uefl_pkg::uefl_parity_t par;
  int failures = 0, checks_done = 0, rxc = 0, txc = 0;
  logic [4:0] rxth [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};

  // ======================================================================
  // clock, bit-time ticks every other cycle, clear pulse counters
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) baud_tick <= tick_en & ~baud_tick;
  always @(posedge pclk) begin
    if (rx_clr === 1'b1) rxc++;
    if (tx_clr === 1'b1) txc++;
  end

  uefl_apb_host u_uefl_apb_host (.pclk(pclk), .presetn(presetn),
    .go(go), .go_wr(go_wr), .go_addr(go_addr), .go_data(go_data),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .done(h_done), .rdata(h_rdata), .err(h_err));

  uefl_core u_uefl_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata), .pready_q(pready), .pslverr_q(pslverr),
    .rx_level(rx_level), .tx_level(tx_level), .rhr_full(rhr_full),
    .thr_empty(thr_empty), .tx_all_empty(tx_all_empty),
    .overrun_err(overrun_err), .char_err(char_err),
    .modem_delta(modem_delta), .rx_push(pul[0]), .rx_pop(pul[1]),
    .tx_push(pul[2]), .baud_tick(baud_tick), .fifo_on_q(fifo_on),
    .rx_clear_q(rx_clr), .tx_clear_q(tx_clr), .extended_q(ext),
    .bank_q(bank), .char_len_q(len), .stop_code_q(stop),
    .parity_kind_q(par));

  // ======================================================================
  // tasks and expected-value helpers
  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one apb transfer; the wait is bounded so a silent slave cannot hang
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    go <= 1'b1;
    go_wr <= w;
    go_addr <= a;
    go_data <= d;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    while (h_done !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHECK_EQ(h_rdata, e)
  endtask

  task automatic pulse(input int b);
    @(posedge pclk);
    pul[b] <= 1'b1;
    @(posedge pclk);
    pul <= 3'h0;
  endtask

  function automatic uefl_pkg::uefl_parity_t exp_par(input logic [7:0] v);
    if (!v[3]) return uefl_pkg::UEFL_PAR_NONE;
    if (v[5]) return v[4] ? uefl_pkg::UEFL_PAR_ZERO : uefl_pkg::UEFL_PAR_ONE;
    return v[4] ? uefl_pkg::UEFL_PAR_EVEN : uefl_pkg::UEFL_PAR_ODD;
  endfunction

  function automatic uefl_pkg::uefl_stop_t exp_stop(input logic [7:0] v);
    if (!v[2]) return uefl_pkg::UEFL_STOP_ONE;
    return (v[1:0] == 2'h0) ? uefl_pkg::UEFL_STOP_HALF :
                              uefl_pkg::UEFL_STOP_TWO;
  endfunction

  // ======================================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    {rx_level, tx_level, modem_delta} = 14'h0;
    {rhr_full, thr_empty, tx_all_empty, overrun_err, char_err} = 5'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset state: legacy, nothing pending, format and bank zero
    rd(`UEFL_OFS_EVT, 32'h01);
    rd(`UEFL_OFS_LINE, 32'h00);
    `CHECK_EQ(stop, uefl_pkg::UEFL_STOP_ONE)
    `CHECK_EQ(ext, 1'b0)
    // legacy priorities, transmit empty then modem up to line raised, then dropped
    thr_empty <= 1'b1;
    rd(`UEFL_OFS_EVT, 32'h02);
    rd(`UEFL_OFS_EVT, 32'h01);
    thr_empty <= 1'b0;
    @(posedge pclk);
    thr_empty <= 1'b1;
    pulse(2);
    rd(`UEFL_OFS_EVT, 32'h01);
    modem_delta <= 4'h1;
    rd(`UEFL_OFS_EVT, 32'h00);
    rhr_full <= 1'b1;
    rd(`UEFL_OFS_EVT, 32'h04);
    char_err <= 1'b1;
    rd(`UEFL_OFS_EVT, 32'h06);
    {char_err, rhr_full, modem_delta, thr_empty} <= 7'h0;
    tx_level <= 5'h05;
    // fifos on: each receive threshold, just below and at it
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `UEFL_OFS_EVT, {24'h0, i[1:0], 6'h01});
      `CHECK_EQ(fifo_on, 1'b1)
      rx_level <= rxth[i] - 5'h01;
      rd(`UEFL_OFS_EVT, 32'hc1);
      rx_level <= rxth[i];
      rd(`UEFL_OFS_EVT, 32'hc4);
    end
    // time-out: 5 bits, no parity, one stop gives 28 bit times
    xfer(1'b1, `UEFL_OFS_EVT, 32'h41);
    rx_level <= 5'h01;
    tick_en <= 1'b1;
    pulse(0);
    repeat (40) @(posedge pclk);
    rd(`UEFL_OFS_EVT, 32'hc1);
    pulse(1);
    repeat (40) @(posedge pclk);
    rd(`UEFL_OFS_EVT, 32'hc1);
    repeat (40) @(posedge pclk);
    rd(`UEFL_OFS_EVT, 32'hcc);
    pulse(1);
    rd(`UEFL_OFS_EVT, 32'hc1);
    tick_en <= 1'b0;
    rx_level <= 5'h00;
    // extended mode: separate flags, transmit threshold 9
    xfer(1'b1, `UEFL_OFS_EXT, 32'h1);
    rd(`UEFL_OFS_EXT, 32'h1);
    `CHECK_EQ(ext, 1'b1)
    rd(`UEFL_OFS_EVT, 32'h00);
    xfer(1'b1, `UEFL_OFS_EVT, 32'h21);
    rd(`UEFL_OFS_EVT, 32'h02);
    tx_level <= 5'h09;
    rd(`UEFL_OFS_EVT, 32'h00);
    rx_level <= 5'h01;
    rd(`UEFL_OFS_EVT, 32'h01);
    overrun_err <= 1'b1;
    rd(`UEFL_OFS_EVT, 32'h05);
    modem_delta <= 4'h8;
    rd(`UEFL_OFS_EVT, 32'h0d);
    tx_all_empty <= 1'b1;
    rd(`UEFL_OFS_EVT, 32'h2d);
    // self-clearing soft clears and fifo disable
    // one more edge so the pulse counters have settled before the look
    xfer(1'b1, `UEFL_OFS_EVT, 32'h03);
    @(posedge pclk);
    `CHECK_EQ(rxc, 1)
    xfer(1'b1, `UEFL_OFS_EVT, 32'h05);
    @(posedge pclk);
    `CHECK_EQ(txc, 1)
    xfer(1'b1, `UEFL_OFS_EVT, 32'h00);
    @(posedge pclk);
    `CHECK_EQ(rxc + txc, 4)
    `CHECK_EQ(fifo_on, 1'b0)
    // every format setting with the gate clear
    for (int v = 0; v < 64; v++) begin
      xfer(1'b1, `UEFL_OFS_LINE, v);
      repeat (2) @(posedge pclk);
      `CHECK_EQ(len, v[1:0])
      `CHECK_EQ(stop, exp_stop(v[7:0]))
      `CHECK_EQ(par, exp_par(v[7:0]))
      `CHECK_EQ(bank, v[7:0])
    end
    // gate set: bank only, format kept
    xfer(1'b1, `UEFL_OFS_LINE, 32'h80);
    repeat (2) @(posedge pclk);
    `CHECK_EQ(len, 2'h3)
    rd(`UEFL_OFS_LINE, 32'h80);
    // unmapped address answers with an error
    xfer(1'b0, 8'h40, 32'h0);
    `CHECK_EQ(h_err, 1'b1)
    tally_and_finish();
  end
endmodule
